//--- core/ssf_pkg.sv
// Package with constants and carriers of the serial status flag logic
package ssf_pkg;

	// Register port widths
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h1;

	// Status bit positions
	localparam int BIT_TX_EMPTY = 7;
	localparam int BIT_RX_FULL  = 6;
	localparam int BIT_OVERRUN  = 5;
	localparam int BIT_ERRSIG   = 4;
	localparam int BIT_PARITY   = 3;
	localparam int BIT_TX_DONE  = 2;
	localparam int BIT_RX_MPB   = 1;
	localparam int BIT_TX_MPB   = 0;

	// Control bit positions
	localparam int BIT_CARD_MODE = 0;
	localparam int BIT_TX_ON     = 1;
	localparam int BIT_RX_ON     = 2;
	localparam int BIT_EARLY_END = 3;
	localparam int BIT_BLOCK     = 4;

	// Reset values
	localparam logic [DATA_W-1:0] RST_STATUS = 8'h84;
	localparam logic [DATA_W-1:0] RST_CTRL   = 8'h00;

	// Transmit end delay in half-etu ticks
	localparam logic [2:0] TICKS_NORMAL_XFER = 3'h5;
	localparam logic [2:0] TICKS_BLOCK_XFER  = 3'h3;
	localparam logic [2:0] TICKS_EARLY_END   = 3'h2;

	// Channel events, one-cycle pulses on clk except rx_mpb, a level read with rx_done
	typedef struct packed {
		logic tx_load;
		logic tx_start;
		logic tx_last_bit;
		logic half_etu_tick;
		logic rx_done;
		logic rx_mpb;
		logic rx_parity_err;
		logic rx_frame_err;
		logic err_sample;
	} ssf_chan_evt_type;

	// Settings handed to the channel
	typedef struct packed {
		logic card_mode;
		logic tx_on;
		logic rx_on;
		logic early_end;
		logic block_xfer;
		logic tx_mpb;
	} ssf_chan_cfg_type;

	// Transmit end timer states
	typedef enum logic [0:0] {
		TM_IDLE = 1'b0,
		TM_RUN  = 1'b1
	} ssf_timer_type;

endpackage

//--- core/ssf_status_flags.sv
// Status flag register bank of one serial channel
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
module ssf_status_flags (
	input  wire logic                      clk,
	input  wire logic                      arst_n,
	input  wire logic [ssf_pkg::ADDR_W-1:0] addr,
	input  wire logic [ssf_pkg::DATA_W-1:0] wdata,
	input  wire logic                      wr_stb,
	input  wire logic                      rd_stb,
	output logic      [ssf_pkg::DATA_W-1:0] rdata,
	input  wire ssf_pkg::ssf_chan_evt_type evt,
	input  wire logic                      err_line_in,
	output ssf_pkg::ssf_chan_cfg_type      cfg,
	output logic      [ssf_pkg::DATA_W-1:0] flags
);
	import ssf_pkg::*;

	// Flag and register flops
	logic                tx_empty_reg;      // Transmit buffer empty
	logic                rx_full_reg;       // Receive buffer full
	logic                overrun_reg;       // Overrun
	logic                errsig_reg;        // Framing or error signal
	logic                parity_reg;        // Parity failure
	logic                tx_done_reg;       // Transmit complete
	logic                rx_mpb_reg;        // Received multiprocessor bit
	logic                tx_mpb_reg;        // Multiprocessor bit to send
	logic [DATA_W-1:0]   ctrl_reg;          // Control settings
	logic [DATA_W-1:0]   armed_reg;         // Bits read as one
	logic [DATA_W-1:0]   rdata_reg;         // Read answer
	logic [DATA_W-1:0]   flags_reg;         // Flag mirror
	ssf_chan_cfg_type    cfg_reg;           // Settings mirror

	// Error line synchroniser and filtered level
	logic                err_s1_reg;
	logic                err_s2_reg;
	logic                err_s3_reg;
	logic                err_level_reg;

	// Transmit end timer
	ssf_timer_type       tm_state_reg;
	logic [2:0]          tm_cnt_reg;
	logic [2:0]          tm_target;
	logic                tm_expire;

	// Decoded accesses and settings
	logic                wr_status;
	logic                wr_ctrl;
	logic                card_mode;
	logic                tx_on;
	logic                rx_on;
	logic [DATA_W-1:0]   status_now;
	logic [DATA_W-1:0]   clr;

	assign card_mode = ctrl_reg[BIT_CARD_MODE];
	assign tx_on     = ctrl_reg[BIT_TX_ON];
	assign rx_on     = ctrl_reg[BIT_RX_ON];
	assign wr_status = wr_stb && (addr == OFS_STATUS);
	assign wr_ctrl   = wr_stb && (addr == OFS_CTRL);

	// Status word as software sees it; bit 4 meaning follows the mode
	always_comb
	begin
		status_now               = '0;
		status_now[BIT_TX_EMPTY] = tx_empty_reg;
		status_now[BIT_RX_FULL]  = rx_full_reg;
		status_now[BIT_OVERRUN]  = overrun_reg;
		status_now[BIT_ERRSIG]   = errsig_reg;
		status_now[BIT_PARITY]   = parity_reg;
		status_now[BIT_TX_DONE]  = tx_done_reg;
		status_now[BIT_RX_MPB]   = rx_mpb_reg;
		status_now[BIT_TX_MPB]   = tx_mpb_reg;
	end

	// Clear only a bit read as one and then written as zero
	always_comb
	begin
		clr = '0;
		if (wr_status)
		begin
			clr = armed_reg & ~wdata;
		end
	end

	// Arming: a status read remembers which bits were one
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			armed_reg <= '0;
		end
		else if (rd_stb && (addr == OFS_STATUS))
		begin
			armed_reg <= status_now;
		end
		else if (wr_status)
		begin
			// A status write spends the arming, so a stale read cannot clear later
			armed_reg <= '0;
		end
	end

	// Control register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_reg <= RST_CTRL;
		end
		else if (wr_ctrl)
		begin
			ctrl_reg <= {3'h0, wdata[4:0]};
		end
	end

	// Three flop error line synchroniser
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			err_s1_reg <= 1'b1;
			err_s2_reg <= 1'b1;
			err_s3_reg <= 1'b1;
		end
		else
		begin
			err_s1_reg <= err_line_in;
			err_s2_reg <= err_s1_reg;
			err_s3_reg <= err_s2_reg;
		end
	end

	// Level accepted once two settled stages agree; idle line is high
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			err_level_reg <= 1'b1;
		end
		else if (err_s2_reg == err_s3_reg)
		begin
			err_level_reg <= err_s3_reg;
		end
	end

	// Delay target from early-end and block settings
	always_comb
	begin
		if (ctrl_reg[BIT_EARLY_END])
		begin
			tm_target = TICKS_EARLY_END;
		end
		else if (ctrl_reg[BIT_BLOCK])
		begin
			tm_target = TICKS_BLOCK_XFER;
		end
		else
		begin
			tm_target = TICKS_NORMAL_XFER;
		end
	end

	assign tm_expire = (tm_state_reg == TM_RUN) && evt.half_etu_tick
		&& ((tm_cnt_reg + 3'h1) == tm_target);

	// Transmit end timer, started by a card mode transmission start while idle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tm_state_reg <= TM_IDLE;
			tm_cnt_reg   <= 3'h0;
		end
		else
		begin
			case (tm_state_reg)
				TM_IDLE:
				begin
					if (evt.tx_start && card_mode && tx_on)
					begin
						tm_state_reg <= TM_RUN;
						tm_cnt_reg   <= 3'h0;
					end
				end
				TM_RUN:
				begin
					// Disabling stops the wait; the flag is set directly then only while bit 4 is clear
					if (!tx_on || !card_mode || tm_expire)
					begin
						tm_state_reg <= TM_IDLE;
					end
					else if (evt.half_etu_tick)
					begin
						tm_cnt_reg <= tm_cnt_reg + 3'h1;
					end
				end
				default:
				begin
					tm_state_reg <= TM_IDLE;
				end
			endcase
		end
	end

	// Transmit buffer empty; set wins over clear
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tx_empty_reg <= RST_STATUS[BIT_TX_EMPTY];
		else if (!tx_on || evt.tx_load)
			tx_empty_reg <= 1'b1;
		else if (clr[BIT_TX_EMPTY])
			tx_empty_reg <= 1'b0;
	end

	// Transmit complete, cleared together with the empty flag
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tx_done_reg <= RST_STATUS[BIT_TX_DONE];
		else if (!card_mode && (!tx_on || (evt.tx_last_bit && tx_empty_reg)))
			tx_done_reg <= 1'b1;
		else if (card_mode && !tx_on && !errsig_reg)
			tx_done_reg <= 1'b1;
		else if (card_mode && tm_expire && !errsig_reg && tx_empty_reg)
			tx_done_reg <= 1'b1;
		else if (clr[BIT_TX_EMPTY])
			tx_done_reg <= 1'b0;
	end

	// Receive full; set wins, receiver disable does not touch it
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rx_full_reg <= RST_STATUS[BIT_RX_FULL];
		else if (evt.rx_done)
			rx_full_reg <= 1'b1;
		else if (clr[BIT_RX_FULL])
			rx_full_reg <= 1'b0;
	end

	// Overrun: a reception finishing on a full buffer
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			overrun_reg <= RST_STATUS[BIT_OVERRUN];
		else if (evt.rx_done && rx_full_reg)
			overrun_reg <= 1'b1;
		else if (clr[BIT_OVERRUN])
			overrun_reg <= 1'b0;
	end

	// Bit 4: framing failure normally, returned error signal in card mode
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			errsig_reg <= RST_STATUS[BIT_ERRSIG];
		else if (card_mode && evt.err_sample && !err_level_reg)
			errsig_reg <= 1'b1;
		else if (!card_mode && evt.rx_frame_err)
			errsig_reg <= 1'b1;
		else if (clr[BIT_ERRSIG])
			errsig_reg <= 1'b0;
	end

	// Parity failure
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			parity_reg <= RST_STATUS[BIT_PARITY];
		else if (evt.rx_parity_err)
			parity_reg <= 1'b1;
		else if (clr[BIT_PARITY])
			parity_reg <= 1'b0;
	end

	// Received multiprocessor bit; read-only, held while receiver is off
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rx_mpb_reg <= RST_STATUS[BIT_RX_MPB];
		else if (evt.rx_done && rx_on && !card_mode)
			rx_mpb_reg <= evt.rx_mpb;
	end

	// Multiprocessor bit to send; plain read/write bit
	// Software is expected to keep it zero in card mode
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tx_mpb_reg <= RST_STATUS[BIT_TX_MPB];
		else if (wr_status)
			tx_mpb_reg <= wdata[BIT_TX_MPB];
	end

	// Read answer stands only in the cycle after the strobe
	// Unmapped reads and idle cycles give zero
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_reg <= '0;
		else if (rd_stb && (addr == OFS_STATUS))
			rdata_reg <= status_now;
		else if (rd_stb && (addr == OFS_CTRL))
			rdata_reg <= ctrl_reg;
		else
			rdata_reg <= '0;
	end

	// Registered mirrors toward the channel; one cycle behind the flops
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			flags_reg <= RST_STATUS;
			cfg_reg   <= '0;
		end
		else
		begin
			flags_reg          <= status_now;
			cfg_reg.card_mode  <= card_mode;
			cfg_reg.tx_on      <= tx_on;
			cfg_reg.rx_on      <= rx_on;
			cfg_reg.early_end  <= ctrl_reg[BIT_EARLY_END];
			cfg_reg.block_xfer <= ctrl_reg[BIT_BLOCK];
			cfg_reg.tx_mpb     <= tx_mpb_reg;
		end
	end

	assign rdata = rdata_reg;
	assign flags = flags_reg;
	assign cfg   = cfg_reg;

endmodule

//--- bench/ssf_peer_model.sv
// Far-side channel model: event pulses and card error line
`timescale 1ns/1ps
module ssf_peer_model (
	input  wire logic                clk,
	output ssf_pkg::ssf_chan_evt_type evt,
	output logic                     err_line_in
);
	import ssf_pkg::*;
	// Idle: no events, error line pulled high
	initial
	begin
		evt = '0;
		err_line_in = 1'b1;
	end
	// One-cycle pulse on event bit b, then a quiet cycle
	task pulse(input int b);
		evt[b] <= 1'b1;
		@(posedge clk);
		evt[b] <= 1'b0;
		@(posedge clk);
	endtask
	// Received frame with its mpb and parity outcome
	task rx(input logic m, input logic p);
		evt.rx_done <= 1'b1;
		evt.rx_mpb <= m;
		evt.rx_parity_err <= p;
		@(posedge clk);
		evt.rx_done <= 1'b0;
		evt.rx_parity_err <= 1'b0;
		evt.rx_mpb <= !m; // Stale level must not pass for valid
		@(posedge clk);
	endtask
	// Half-etu ticks, four cycles apart
	task ticks(input int n);
		repeat (n)
		begin
			pulse(5);
			repeat (2) @(posedge clk);
		end
	endtask
	// Card pulls the error line low; sampled after the filter settles
	task err;
		err_line_in <= 1'b0;
		repeat (6) @(posedge clk);
		pulse(0);
		err_line_in <= 1'b1;
		@(posedge clk);
	endtask
endmodule

//--- bench/ssf_status_flags_monitor.sv
// Port checker for the status flag bank
`timescale 1ns/1ps
module ssf_status_flags_monitor (
	input wire logic                       clk,
	input wire logic                       arst_n,
	input wire logic [ssf_pkg::ADDR_W-1:0] addr,
	input wire logic [ssf_pkg::DATA_W-1:0] wdata,
	input wire logic                       wr_stb,
	input wire logic                       rd_stb,
	input wire logic [ssf_pkg::DATA_W-1:0] rdata,
	input wire ssf_pkg::ssf_chan_evt_type  evt,
	input wire logic                       err_line_in,
	input wire ssf_pkg::ssf_chan_cfg_type  cfg,
	input wire logic [ssf_pkg::DATA_W-1:0] flags
);
	import ssf_pkg::*;
	// flags lags the internal word by one cycle, hence the ##2 below
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_rx_sets_full: assert property (evt.rx_done |-> ##2 flags[BIT_RX_FULL])
		else $error("full flag not set");
	a_overrun_on_full: assert property (evt.rx_done && flags[BIT_RX_FULL] &&
		!$past(wr_stb) |-> ##2 flags[BIT_OVERRUN])
		else $error("overrun not set");
	a_parity_set: assert property (evt.rx_parity_err |-> ##2 flags[BIT_PARITY])
		else $error("parity flag not set");
	a_parity_cause: assert property ($rose(flags[BIT_PARITY]) |->
		$past(evt.rx_parity_err, 2))
		else $error("parity flag rose alone");
	a_errsig_cause: assert property ($rose(flags[BIT_ERRSIG]) |->
		$past(evt.rx_frame_err, 2) || $past(evt.err_sample, 2))
		else $error("bit 4 rose alone");
	a_mpb_cause: assert property ($changed(flags[BIT_RX_MPB]) |->
		$past(evt.rx_done, 2) && !$past(cfg.card_mode) && $past(cfg.rx_on))
		else $error("rx mpb changed alone");
	a_txoff_sets: assert property (!cfg.tx_on |=> flags[BIT_TX_EMPTY] &&
		(flags[BIT_TX_DONE] || $past(cfg.card_mode)))
		else $error("tx off did not set flags");
	a_done_clear: assert property ($fell(flags[BIT_TX_DONE]) |-> $past(wr_stb, 2) &&
		$past(addr, 2) == OFS_STATUS && !$past(wdata[BIT_TX_EMPTY], 2))
		else $error("tx done fell alone");
	c_overrun: cover property (evt.rx_done && flags[BIT_RX_FULL]);
	c_card_done: cover property (cfg.card_mode && $rose(flags[BIT_TX_DONE]));
	c_errsig: cover property (cfg.card_mode && $rose(flags[BIT_ERRSIG]));
endmodule
bind ssf_status_flags ssf_status_flags_monitor i_mon (.clk(clk), .arst_n(arst_n),
	.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
	.evt(evt), .err_line_in(err_line_in), .cfg(cfg), .flags(flags));

//--- bench/serial_status_flag_logic_tb.sv
// Self-checking bench of the status flag bank
`timescale 1ns/1ps
module serial_status_flag_logic_tb;
	import ssf_pkg::*;
	logic             clk;
	logic             arst_n;
	logic [3:0]       addr;
	logic [7:0]       wdata;
	logic             wr_stb;
	logic             rd_stb;
	logic [7:0]       rdata;
	ssf_chan_evt_type evt;
	logic             err_line_in;
	ssf_chan_cfg_type cfg;
	logic [7:0]       flags;
	logic [7:0]       e;      // Expected status word
	logic             m;
	logic             p;
	int               bad_count;
	int               tests_run;
	ssf_status_flags i_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .evt(evt),
		.err_line_in(err_line_in), .cfg(cfg), .flags(flags));
	ssf_peer_model i_peer (.clk(clk), .evt(evt), .err_line_in(err_line_in));
	// 100 MHz clock
	always #5 clk = ~clk;
	// Compare one byte
	task chk(input string n, input logic [7:0] x, input logic [7:0] g);
		tests_run++;
		if (g !== x)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask
	// Bus write, then a quiet cycle
	task wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		@(posedge clk);
	endtask
	// Bus read; data stand only in the next cycle
	task rd(input logic [3:0] a, input logic [7:0] x);
		logic [7:0] g;
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 g = rdata;
		@(posedge clk);
		chk("rdata", x, g);
	endtask
	// Status after one reception with parity outcome pe
	function logic [7:0] rx_exp(input logic [7:0] s, input logic mb, input logic pe);
		rx_exp = s;
		rx_exp[BIT_OVERRUN] = s[BIT_OVERRUN] | s[BIT_RX_FULL];
		rx_exp[BIT_RX_FULL] = 1'b1;
		rx_exp[BIT_PARITY] = s[BIT_PARITY] | pe;
		rx_exp[BIT_RX_MPB] = mb;
	endfunction
	// Half-etu ticks until card transmit end
	function int n_ticks(input logic early, input logic block_transfer_mode);
		n_ticks = early ? 2 : (block_transfer_mode ? 3 : 5);
	endfunction
	// Counts, verdict, end of run
	task results;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		results();
	end
	initial
	begin
		clk = 1'b0;
		arst_n = 1'b0;
		addr = '0;
		wdata = '0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		bad_count = 0;
		tests_run = 0;
		m = 1'($urandom(32'hb306));
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk("flags", RST_STATUS, flags);
		rd(OFS_STATUS, 8'h84);
		wr(OFS_CTRL, 8'h06);
		rd(OFS_STATUS, 8'h84);
		wr(OFS_STATUS, 8'hf9);
		rd(OFS_STATUS, 8'h85);
		wr(OFS_STATUS, 8'h01);
		rd(OFS_STATUS, 8'h01);
		chk("tx mpb", 8'h01, {7'h0, cfg.tx_mpb});
		rd(4'h9, 8'h00);
		wr(4'h9, 8'hff);
		rd(OFS_CTRL, 8'h06);
		$display("test registers done");
		e = 8'h01;
		repeat (10)
		begin
			m = 1'($urandom);
			p = 1'($urandom);
			i_peer.rx(m, p);
			e = rx_exp(e, m, p);
			rd(OFS_STATUS, e);
			if ($urandom % 2)
			begin
				wr(OFS_STATUS, 8'h01);
				e = e & 8'h07;
				rd(OFS_STATUS, e);
			end
		end
		i_peer.rx(1'b0, 1'b0);
		e = rx_exp(e, 1'b0, 1'b0);
		i_peer.pulse(1);
		e[BIT_ERRSIG] = 1'b1;
		wr(OFS_CTRL, 8'h02);
		rd(OFS_STATUS, e);
		wr(OFS_CTRL, 8'h00);
		e = e | 8'h84;
		rd(OFS_STATUS, e);
		wr(OFS_CTRL, 8'h02);
		rd(OFS_STATUS, e);
		wr(OFS_STATUS, 8'h01);
		e = e & 8'h03;
		i_peer.pulse(8);
		i_peer.pulse(6);
		e = e | 8'h84;
		rd(OFS_STATUS, e);
		$display("test normal mode done");
		for (int k = 0; k < 4; k++)
		begin
			wr(OFS_CTRL, {3'h0, k[1], k[0], 3'h7});
			rd(OFS_STATUS, e);
			wr(OFS_STATUS, 8'h00);
			e = e & 8'h02;
			i_peer.pulse(8);
			e[BIT_TX_EMPTY] = 1'b1;
			i_peer.pulse(7);
			i_peer.ticks(n_ticks(k[0], k[1]) - 1);
			chk("flags", e, flags);
			i_peer.ticks(1);
			e[BIT_TX_DONE] = 1'b1;
			chk("flags", e, flags);
			chk("cfg", {2'h0, 3'h7, k[0], k[1], 1'b0}, {2'h0, cfg});
			i_peer.rx(!e[BIT_RX_MPB], 1'b0);
			e = rx_exp(e, e[BIT_RX_MPB], 1'b0);
			rd(OFS_STATUS, e);
		end
		$display("test card timing done");
		rd(OFS_STATUS, e);
		wr(OFS_STATUS, 8'h00);
		e = e & 8'h02;
		i_peer.err();
		e[BIT_ERRSIG] = 1'b1;
		wr(OFS_CTRL, 8'h01);
		e[BIT_TX_EMPTY] = 1'b1;
		rd(OFS_STATUS, e);
		wr(OFS_STATUS, 8'h00);
		e = (e & 8'h02) | 8'h84;
		rd(OFS_STATUS, e);
		$display("test error signal done");
		results();
	end
endmodule
